// ---- verilog/option_byte_map.svh ----
`ifndef OPTION_BYTE_MAP_SVH
`define OPTION_BYTE_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OB_ADDR_BYTE0     12'h000
`define OB_ADDR_BYTE1     12'h004
`define OB_ADDR_STATUS    12'h008
`define OB_ADDR_SETTINGS  12'h00c

// ----------------------------------------------------------------------
// Cell contents
// ----------------------------------------------------------------------
`define OB_ERASED_VALUE   8'hff
`define OB_CLEARED_VALUE  8'h00
`define OB_ROM_BYTE0      8'hfe
`define OB_ROM_BYTE1      8'hef

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OB0_AMP_BIT       1
`define OB0_PROTECT_BIT   0
`define OB1_CLKFILT_BIT   7
`define OB1_OSC_MSB       6
`define OB1_OSC_LSB       4
`define OB1_LVD_MSB       3
`define OB1_LVD_LSB       2
`define OB1_HALT_BIT      1
`define OB1_SOFTWDG_BIT   0

// ----------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------
`define OB_STAT_PROG_BIT  0
`define OB_STAT_ERASE_BIT 1
`define OB_STAT_WDG_BIT   2

// ----------------------------------------------------------------------
// Timing and bus answers
// ----------------------------------------------------------------------
`define OB_ERASE_CYCLES   16
`define OB_RESP_OKAY      2'b00
`define OB_RESP_SLVERR    2'b10

`endif

// ---- verilog/option_byte_pkg.sv ----
package option_byte_pkg;

    typedef enum logic [6:0] {
        OSC_EXT_CLOCK  = 7'b0000001,
        OSC_INT_RC     = 7'b0000010,
        OSC_EXT_RC     = 7'b0000100,
        OSC_LOW_POWER  = 7'b0001000,
        OSC_MID_POWER  = 7'b0010000,
        OSC_MID_SPEED  = 7'b0100000,
        OSC_HIGH_SPEED = 7'b1000000
    } osc_t;

    typedef enum logic [1:0] {
        ERASE_IDLE = 2'b01,
        ERASE_RUN  = 2'b10
    } erase_state_t;

    typedef struct packed {
        logic       aux_amp_enable;
        logic       readout_protect;
        logic       clk_filter_off;
        osc_t       osc_select;
        logic       lowvolt_enable;
        logic [1:0] lowvolt_threshold_sel;
        logic       reset_on_halt;
        logic       soft_watchdog_sel;
    } cfg_t;

endpackage : option_byte_pkg

// ---- verilog/option_cfg_if.sv ----
`timescale 1ns/1ps
`default_nettype none

interface option_cfg_if;
    logic [7:0]           byte0;
    logic [7:0]           byte1;
    option_byte_pkg::cfg_t cfg;

    modport store  (output byte0, output byte1);
    modport decode (input byte0, input byte1, output cfg);
endinterface : option_cfg_if

`default_nettype wire

// ---- verilog/option_cell_store.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "option_byte_map.svh"

module option_cell_store #(
    parameter bit MASK_ROM = 1'b0
) (
    input  wire logic       aclk,
    input  wire logic       por_n,
    input  wire logic       wr_en,
    input  wire logic       wr_sel,
    input  wire logic [7:0] wr_data,
    input  wire logic       erase,
    option_cfg_if.store     cfg_if
);

    // ------------------------------------------------------------------
    // Cells
    // ------------------------------------------------------------------
    generate
        if (MASK_ROM) begin : g_rom
            // Fixed by the ROM code; programming has no effect
            assign cfg_if.byte0 = `OB_ROM_BYTE0;
            assign cfg_if.byte1 = `OB_ROM_BYTE1;
        end else begin : g_flash
            logic [7:0] cell_reg [2];

            // Cells survive aresetn; only delivery state (por_n) blanks them
            always_ff @(posedge aclk) begin
                if (!por_n) begin
                    cell_reg[0] <= `OB_ERASED_VALUE;
                    cell_reg[1] <= `OB_ERASED_VALUE;
                end else if (erase) begin
                    cell_reg[0] <= `OB_CLEARED_VALUE;
                    cell_reg[1] <= `OB_CLEARED_VALUE;
                end else if (wr_en) begin
                    cell_reg[wr_sel] <= wr_data;
                end
            end

            assign cfg_if.byte0 = cell_reg[0];
            assign cfg_if.byte1 = cell_reg[1];
        end
    endgenerate

endmodule : option_cell_store

`default_nettype wire

// ---- verilog/option_field_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "option_byte_map.svh"

module option_field_decode (
    option_cfg_if.decode cfg_if
);

    // ------------------------------------------------------------------
    // Field decoders
    // ------------------------------------------------------------------
    function automatic option_byte_pkg::osc_t decode_osc(input logic [2:0] code);
        case (code)
            3'h7:    decode_osc = option_byte_pkg::OSC_EXT_CLOCK;
            3'h6:    decode_osc = option_byte_pkg::OSC_INT_RC;
            3'h5,
            3'h4:    decode_osc = option_byte_pkg::OSC_EXT_RC;
            3'h3:    decode_osc = option_byte_pkg::OSC_LOW_POWER;
            3'h2:    decode_osc = option_byte_pkg::OSC_MID_POWER;
            3'h1:    decode_osc = option_byte_pkg::OSC_MID_SPEED;
            default: decode_osc = option_byte_pkg::OSC_HIGH_SPEED;
        endcase
    endfunction : decode_osc

    always_comb begin
        cfg_if.cfg.aux_amp_enable        = cfg_if.byte0[`OB0_AMP_BIT];
        cfg_if.cfg.readout_protect       = cfg_if.byte0[`OB0_PROTECT_BIT];
        cfg_if.cfg.clk_filter_off        = cfg_if.byte1[`OB1_CLKFILT_BIT];
        cfg_if.cfg.osc_select            = decode_osc(cfg_if.byte1[`OB1_OSC_MSB:`OB1_OSC_LSB]);
        // Code 11 switches the detector off; others pick a threshold
        cfg_if.cfg.lowvolt_enable        = ~&cfg_if.byte1[`OB1_LVD_MSB:`OB1_LVD_LSB];
        cfg_if.cfg.lowvolt_threshold_sel = cfg_if.byte1[`OB1_LVD_MSB:`OB1_LVD_LSB];
        cfg_if.cfg.reset_on_halt         = cfg_if.byte1[`OB1_HALT_BIT];
        cfg_if.cfg.soft_watchdog_sel     = cfg_if.byte1[`OB1_SOFTWDG_BIT];
    end

endmodule : option_field_decode

`default_nettype wire

// ---- verilog/option_byte_config_decode.sv ----
// Chosen here: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "option_byte_map.svh"

module option_byte_config_decode #(
    parameter int ADDR_W       = 12,
    parameter int ERASE_CYCLES = `OB_ERASE_CYCLES,
    parameter bit MASK_ROM     = 1'b0
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 por_n,
    input  wire logic                 prog_mode,
    input  wire logic                 halt_entry,
    input  wire logic                 soft_watchdog_sel_start,
    input  wire logic [ADDR_W-1:0]    awaddr,
    input  wire logic [2:0]           awprot,
    input  wire logic                 awvalid,
    output var  logic                 awready,
    input  wire logic [31:0]          wdata,
    input  wire logic [3:0]           wstrb,
    input  wire logic                 wvalid,
    output var  logic                 wready,
    output var  logic [1:0]           bresp,
    output var  logic                 bvalid,
    input  wire logic                 bready,
    input  wire logic [ADDR_W-1:0]    araddr,
    input  wire logic [2:0]           arprot,
    input  wire logic                 arvalid,
    output var  logic                 arready,
    output var  logic [31:0]          rdata,
    output var  logic [1:0]           rresp,
    output var  logic                 rvalid,
    input  wire logic                 rready,
    output var  logic                 aux_amp_enable,
    output var  logic                 readout_protect,
    output var  logic                 clk_filter_off,
    output var  option_byte_pkg::osc_t osc_select,
    output var  logic                 lowvolt_enable,
    output var  logic [1:0]           lowvolt_threshold_sel,
    output var  logic                 watchdog_enable,
    output var  logic                 halt_reset,
    output var  logic                 mem_erase_active
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic is_option_addr(input logic [ADDR_W-1:0] a);
        is_option_addr = (a == `OB_ADDR_BYTE0) || (a == `OB_ADDR_BYTE1);
    endfunction : is_option_addr

    function automatic logic is_known_addr(input logic [ADDR_W-1:0] a);
        is_known_addr = is_option_addr(a) || (a == `OB_ADDR_STATUS) ||
                        (a == `OB_ADDR_SETTINGS);
    endfunction : is_known_addr

    // ------------------------------------------------------------------
    // Cells and decode
    // ------------------------------------------------------------------
    option_cfg_if cfg_if ();

    logic       cell_wr_en;
    logic       cell_wr_sel;
    logic [7:0] cell_wr_data;
    logic       erase_start;

    option_cell_store #(
        .MASK_ROM (MASK_ROM)
    ) u_store (
        .aclk    (aclk),
        .por_n   (por_n),
        .wr_en   (cell_wr_en),
        .wr_sel  (cell_wr_sel),
        .wr_data (cell_wr_data),
        .erase   (erase_start),
        .cfg_if  (cfg_if)
    );

    option_field_decode u_decode (
        .cfg_if (cfg_if)
    );

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] aw_addr_reg;
    logic              aw_have_reg;
    logic [7:0]        w_byte_reg;
    logic              w_lane0_reg;
    logic              w_have_reg;
    logic              do_write;

    option_byte_pkg::erase_state_t erase_state_reg;
    logic [15:0]                   erase_cnt_reg;

    assign do_write = aw_have_reg && w_have_reg && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready     <= 1'b0;
            aw_have_reg <= 1'b0;
            aw_addr_reg <= '0;
        end else if (awvalid && awready) begin
            awready     <= 1'b0;
            aw_have_reg <= 1'b1;
            aw_addr_reg <= awaddr;
        end else begin
            if (do_write) begin
                aw_have_reg <= 1'b0;
            end
            awready <= !aw_have_reg && !bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready      <= 1'b0;
            w_have_reg  <= 1'b0;
            w_byte_reg  <= '0;
            w_lane0_reg <= 1'b0;
        end else if (wvalid && wready) begin
            wready      <= 1'b0;
            w_have_reg  <= 1'b1;
            w_byte_reg  <= wdata[7:0];
            w_lane0_reg <= wstrb[0];
        end else begin
            if (do_write) begin
                w_have_reg <= 1'b0;
            end
            wready <= !w_have_reg && !bvalid;
        end
    end

    // Outside programming mode the bytes do not exist: writes vanish
    logic opt_write_ok;
    logic protect_clear;

    assign opt_write_ok  = do_write && is_option_addr(aw_addr_reg) && prog_mode &&
                           w_lane0_reg && (erase_state_reg == option_byte_pkg::ERASE_IDLE);
    assign protect_clear = opt_write_ok && (aw_addr_reg == `OB_ADDR_BYTE0) &&
                           cfg_if.byte0[`OB0_PROTECT_BIT] &&
                           !w_byte_reg[`OB0_PROTECT_BIT];

    // Reserved bits are stored as given; the programmer keeps them at one
    assign cell_wr_en   = opt_write_ok && !protect_clear;
    assign cell_wr_sel  = (aw_addr_reg == `OB_ADDR_BYTE1);
    assign cell_wr_data = w_byte_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= `OB_RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            if (!is_known_addr(aw_addr_reg)) begin
                bresp <= `OB_RESP_SLVERR;
            end else if (is_option_addr(aw_addr_reg) && prog_mode &&
                         erase_state_reg != option_byte_pkg::ERASE_IDLE) begin
                bresp <= `OB_RESP_SLVERR;
            end else begin
                bresp <= `OB_RESP_OKAY;
            end
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Erase sequencer
    // ------------------------------------------------------------------
    // Duration is a stand-in for the array erase time of the flash macro
    assign erase_start = protect_clear;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            erase_state_reg  <= option_byte_pkg::ERASE_IDLE;
            erase_cnt_reg    <= '0;
            mem_erase_active <= 1'b0;
        end else begin
            case (erase_state_reg)
                option_byte_pkg::ERASE_IDLE: begin
                    if (erase_start) begin
                        erase_state_reg  <= option_byte_pkg::ERASE_RUN;
                        erase_cnt_reg    <= 16'(ERASE_CYCLES - 1);
                        mem_erase_active <= 1'b1;
                    end
                end
                option_byte_pkg::ERASE_RUN: begin
                    if (erase_cnt_reg == '0) begin
                        erase_state_reg  <= option_byte_pkg::ERASE_IDLE;
                        mem_erase_active <= 1'b0;
                    end else begin
                        erase_cnt_reg <= erase_cnt_reg - 16'h0001;
                    end
                end
                default: begin
                    erase_state_reg  <= option_byte_pkg::ERASE_IDLE;
                    mem_erase_active <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic [1:0]  rd_resp;

    always_comb begin
        rd_word = 32'h00000000;
        rd_resp = `OB_RESP_OKAY;
        case (araddr)
            `OB_ADDR_BYTE0: begin
                if (prog_mode) begin
                    rd_word[7:0] = cfg_if.byte0;
                end
            end
            `OB_ADDR_BYTE1: begin
                if (prog_mode) begin
                    rd_word[7:0] = cfg_if.byte1;
                end
            end
            `OB_ADDR_STATUS: begin
                rd_word[`OB_STAT_PROG_BIT]  = prog_mode;
                rd_word[`OB_STAT_ERASE_BIT] = mem_erase_active;
                rd_word[`OB_STAT_WDG_BIT]   = watchdog_enable;
            end
            `OB_ADDR_SETTINGS: begin
                rd_word[0]   = aux_amp_enable;
                rd_word[1]   = readout_protect;
                rd_word[2]   = clk_filter_off;
                rd_word[3]   = lowvolt_enable;
                rd_word[5:4] = lowvolt_threshold_sel;
                rd_word[14:8] = osc_select;
            end
            default: begin
                rd_resp = `OB_RESP_SLVERR;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= `OB_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_word;
            rresp   <= rd_resp;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end else begin
            arready <= !rvalid;
        end
    end

    // ------------------------------------------------------------------
    // Latched settings
    // ------------------------------------------------------------------
    // Sampled only while reset is held, so consumers never see a
    // half-programmed byte; a change takes effect after the next reset
    logic reset_on_halt_reg;
    logic soft_watchdog_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aux_amp_enable        <= cfg_if.cfg.aux_amp_enable;
            readout_protect       <= cfg_if.cfg.readout_protect;
            clk_filter_off        <= cfg_if.cfg.clk_filter_off;
            osc_select            <= cfg_if.cfg.osc_select;
            lowvolt_enable        <= cfg_if.cfg.lowvolt_enable;
            lowvolt_threshold_sel <= cfg_if.cfg.lowvolt_threshold_sel;
            reset_on_halt_reg     <= cfg_if.cfg.reset_on_halt;
            soft_watchdog_reg     <= cfg_if.cfg.soft_watchdog_sel;
        end
    end

    // ------------------------------------------------------------------
    // Watchdog and halt
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            watchdog_enable <= !cfg_if.cfg.soft_watchdog_sel;
        end else if (soft_watchdog_reg && soft_watchdog_sel_start) begin
            watchdog_enable <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_reset <= 1'b0;
        end else begin
            halt_reset <= halt_entry && watchdog_enable && reset_on_halt_reg;
        end
    end

endmodule : option_byte_config_decode

`default_nettype wire

// ---- sim/option_byte_config_decode_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none

module option_byte_config_decode_assertions #(
    parameter int ERASE_CYCLES = 16
) (
    input wire logic                  aclk,
    input wire logic                  aresetn,
    input wire logic                  prog_mode,
    input wire logic                  halt_entry,
    input wire logic                  awready,
    input wire logic                  wready,
    input wire logic [1:0]            bresp,
    input wire logic                  bvalid,
    input wire logic                  arready,
    input wire logic                  rvalid,
    input wire logic                  aux_amp_enable,
    input wire logic                  readout_protect,
    input wire logic                  clk_filter_off,
    input wire option_byte_pkg::osc_t osc_select,
    input wire logic                  lowvolt_enable,
    input wire logic [1:0]            lowvolt_threshold_sel,
    input wire logic                  watchdog_enable,
    input wire logic                  halt_reset,
    input wire logic                  mem_erase_active
);
    // ------------------------------------------------------------
    // Erase length counter
    // ------------------------------------------------------------
    logic [7:0] erase_cnt_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn || !mem_erase_active) begin
            erase_cnt_reg <= 8'h00;
        end else begin
            erase_cnt_reg <= erase_cnt_reg + 8'h01;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_halt_cause: assert property (halt_reset |-> $past(halt_entry) && $past(watchdog_enable))
        else $error("halt reset without cause");
    a_cfg_held: assert property ($past(aresetn) |-> $stable({aux_amp_enable, readout_protect,
        clk_filter_off, osc_select, lowvolt_enable, lowvolt_threshold_sel}))
        else $error("settings moved outside reset");
    a_lvd_off: assert property (lowvolt_enable == (lowvolt_threshold_sel != 2'b11))
        else $error("detector enable wrong");
    a_osc_onehot: assert property ($onehot(osc_select))
        else $error("oscillator select not one-hot");
    a_wdg_sticky: assert property ($past(aresetn) && $past(watchdog_enable) |-> watchdog_enable)
        else $error("watchdog dropped");
    a_erase_len: assert property ($fell(mem_erase_active) |-> erase_cnt_reg == ERASE_CYCLES)
        else $error("erase length wrong");
    a_erase_bound: assert property (mem_erase_active |-> erase_cnt_reg < ERASE_CYCLES)
        else $error("erase too long");
    a_erase_prog: assert property ($rose(mem_erase_active) |-> $past(prog_mode))
        else $error("erase outside programming mode");
    a_one_write: assert property (bvalid |-> !awready && !wready)
        else $error("write taken during response");
    a_one_read: assert property (rvalid |-> !arready)
        else $error("read taken during response");

    c_halt: cover property (halt_reset);
    c_erase: cover property ($fell(mem_erase_active));
    c_refuse: cover property (bvalid && bresp == 2'b10);
    c_read: cover property (rvalid);
endmodule : option_byte_config_decode_assertions

bind option_byte_config_decode option_byte_config_decode_assertions #(
    .ERASE_CYCLES(ERASE_CYCLES)
) i_option_byte_config_decode_assertions (.*);

`default_nettype wire

// ---- sim/option_prog_tool.sv ----
`timescale 1ns/1ps
`default_nettype none

module option_prog_tool (
    input  wire logic        aclk,
    output var  logic [11:0] awaddr,
    output var  logic        awvalid,
    input  wire logic        awready,
    output var  logic [31:0] wdata,
    output var  logic        wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output var  logic        bready,
    output var  logic [11:0] araddr,
    output var  logic        arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output var  logic        rready
);
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = {12'hfff, 12'hfff, 32'h5a5a5a5a};
    end

    // ------------------------------------------------------------
    // Bus cycles; released payloads go inverted
    // ------------------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= {24'h000000, (a == 12'h000) ? (d | 8'hfc) : d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
            end
        end while (!bvalid && n < 200);
        r = bresp;
        bready <= 1'b0;
        if (!bvalid) option_byte_config_decode_test.hang();
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~a;
            end
        end while (!rvalid && n < 200);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        if (!rvalid) option_byte_config_decode_test.hang();
    endtask : rd
endmodule : option_prog_tool

`default_nettype wire

// ---- sim/option_byte_config_decode_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module option_byte_config_decode_test;
    localparam int ERASE_N = 8;
    logic                  aclk, aresetn, por_n, prog_mode, halt_entry, soft_watchdog_sel_start;
    logic                  awvalid, awready, wvalid, wready, bvalid, bready;
    logic                  arvalid, arready, rvalid, rready;
    logic [11:0]           awaddr, araddr;
    logic [31:0]           wdata, rdata;
    logic [1:0]            bresp, rresp, lowvolt_threshold_sel, r;
    logic                  aux_amp_enable, readout_protect, clk_filter_off, lowvolt_enable;
    logic                  watchdog_enable, halt_reset, mem_erase_active;
    option_byte_pkg::osc_t osc_select;
    logic [7:0]            d, b1;
    logic [6:0]            prev;
    logic [2:0]            k;
    int                    errors, compares, n;

    option_byte_config_decode #(.ERASE_CYCLES(ERASE_N)) i_option_byte_config_decode (
        .*, .awprot(3'h0), .wstrb(4'h1), .arprot(3'h0)
    );

    option_prog_tool i_option_prog_tool (.*);

    always #2 aclk = ~aclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done

    task automatic hang();
        errors++;
        test_done();
    endtask : hang

    // Cells survive unless blank asks for delivery state
    task automatic reset_dut(input logic blank);
        @(posedge aclk);
        aresetn <= 1'b0;
        por_n   <= !blank;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        por_n   <= 1'b1;
        @(posedge aclk);
    endtask : reset_dut

    task automatic halt_pulse(input logic exp);
        @(posedge aclk);
        halt_entry <= 1'b1;
        @(posedge aclk);
        halt_entry <= 1'b0;
        #1 check(halt_reset, exp);
    endtask : halt_pulse

    task automatic rd(input logic [11:0] a);
        i_option_prog_tool.rd(a, d, r);
    endtask : rd

    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        i_option_prog_tool.wr(a, v, r);
    endtask : wr

    // One-hot position follows the oscillator table order
    function automatic logic [6:0] osc_exp(input logic [2:0] c);
        return 7'h01 << ((c >= 3'h6) ? 3'h7 - c : (c[2] ? 3'h2 : 3'h6 - c));
    endfunction : osc_exp

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {errors, compares} = {32'h0, 32'h0};
        {aclk, aresetn, por_n, prog_mode, halt_entry, soft_watchdog_sel_start} = 6'h00;
        reset_dut(1'b1);
        check({aux_amp_enable, readout_protect, clk_filter_off, lowvolt_enable,
               watchdog_enable}, 32'h1c);
        check(osc_select, option_byte_pkg::OSC_EXT_CLOCK);
        prog_mode <= 1'b1;
        rd(12'h000);
        check({r, d}, 10'h0ff);
        rd(12'h010);
        check({r, d}, 10'h200);
        prog_mode <= 1'b0;
        rd(12'h004);
        check({r, d}, 10'h000);
        wr(12'h004, 8'h00);
        prog_mode <= 1'b1;
        rd(12'h004);
        check({r, d}, 10'h0ff);
        prev = 7'h01;
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            b1 = {k[0], k, k[1:0], k[1], k[2]};
            wr(12'h004, b1);
            check(osc_select, prev);
            reset_dut(1'b0);
            check(osc_select, osc_exp(k));
            check({clk_filter_off, lowvolt_enable, lowvolt_threshold_sel, watchdog_enable},
                  {k[0], k[1:0] != 2'b11, k[1:0], !k[2]});
            prev = osc_exp(k);
        end
        rd(12'h00c);
        check({r, d}, 10'h037);
        // Soft watchdog still off
        halt_pulse(1'b0);
        @(posedge aclk);
        soft_watchdog_sel_start <= 1'b1;
        @(posedge aclk);
        soft_watchdog_sel_start <= 1'b0;
        #1 check(watchdog_enable, 1'b1);
        rd(12'h008);
        check({r, d}, 10'h005);
        halt_pulse(1'b1);
        wr(12'h000, 8'h02);
        wr(12'h004, 8'h55);
        check({r, mem_erase_active}, 3'h5);
        for (n = 0; mem_erase_active === 1'b1; n++) begin
            if (n > 50) hang();
            @(posedge aclk);
        end
        rd(12'h000);
        check({r, d}, 10'h000);
        rd(12'h004);
        check({r, d}, 10'h000);
        reset_dut(1'b0);
        check({aux_amp_enable, readout_protect}, 2'h0);
        wr(12'h000, 8'h02);
        rd(12'h000);
        check(d, 8'hfe);
        reset_dut(1'b0);
        check({aux_amp_enable, readout_protect}, 2'h2);
        wr(12'h000, 8'h01);
        reset_dut(1'b0);
        check({aux_amp_enable, readout_protect, mem_erase_active}, 3'h2);
        test_done();
    end
endmodule : option_byte_config_decode_test

`default_nettype wire
